// ### rtl/dpram_host.sv
// Host controller driving one port of an async dual-port RAM
// Contract
// - Memory or flag select, never both
// - Address changes only while deselected
// - Address held after write end
// - Write pulse long enough; gate stays high
// - Never drive data while device drives
// - Hold strobe low after busy release
// - Flag select pulse meets minimum width
// - Gap between flag write and readback
// - Retention keeps selects inactive
// - Wait past read cycle after power-up
// - Address valid before select falls
// - Each flag read strobed by select
// - Strobe high throughout reads
// - Left top-address write rings right doorbell
// - Right below-top write rings left doorbell
`timescale 1ns/1ps
`include "dpram_host_defines.svh"

module dpram_host
  import dpram_host_pkg::*;
#(
  parameter bit SIDE_LEFT = 1'b1
)
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // Supply status
  input  wire logic                   i_supply_ok,
  input  wire logic                   i_retention,
  // Request
  input  wire logic                   i_req_valid,
  input  wire cmd_t                   i_req_cmd,
  input  wire logic [`DPH_ADDR_W-1:0] i_req_addr,
  input  wire logic [`DPH_DATA_W-1:0] i_req_wdata,
  output      logic                   o_req_ready,
  // Response
  output      logic                   o_rsp_valid,
  output      logic [`DPH_DATA_W-1:0] o_rsp_rdata,
  output      logic                   o_doorbell,
  // Device pins
  output      logic                   o_sel_n,
  output      logic                   o_flag_select_n,
  output      logic                   o_strobe_n,
  output      logic                   o_gate_n,
  output      logic [`DPH_ADDR_W-1:0] o_addr,
  output      logic [`DPH_DATA_W-1:0] o_data,
  output      logic                   o_data_oe,
  input  wire logic [`DPH_DATA_W-1:0] i_data,
  input  wire logic                   i_busy_n,
  input  wire logic                   i_doorbell_n
);
  localparam int WR_CYC   = `DPH_WR_PULSE_CYC;
  localparam int RD_CYC   = `DPH_RD_ACCESS_CYC;
  localparam int FLAG_CYC = `DPH_FLAG_PULSE_CYC;
  localparam int GAP_CYC  = (`DPH_OUT_OFF_CYC > `DPH_FLAG_W2R_CYC) ?
                            `DPH_OUT_OFF_CYC : `DPH_FLAG_W2R_CYC;

  function automatic logic [`DPH_TMR_W-1:0] ld(input int n);
    ld = `DPH_TMR_W'(n - 1);
  endfunction

  function automatic logic is_write(input cmd_t c);
    is_write = (c == CMD_WRITE) || (c == CMD_FLAG_WRITE) ||
               (c == CMD_RING);
  endfunction

  function automatic logic is_flag(input cmd_t c);
    is_flag = (c == CMD_FLAG_WRITE) || (c == CMD_FLAG_READ);
  endfunction

  wait_timer_if tif ();

  wait_timer u_timer
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .tif     (tif)
  );

  state_t                 state_reg;
  state_t                 state_next;
  cmd_t                   cmd_reg;
  logic [`DPH_DATA_W-1:0] rdata_reg;
  logic                   rsp_reg;
  logic                   bell_reg;
  logic [`DPH_ADDR_W-1:0] addr_reg;
  logic [`DPH_DATA_W-1:0] wdata_reg;
  logic                   sel_reg;
  logic                   flag_reg;
  logic                   strobe_reg;
  logic                   gate_reg;
  logic                   oe_reg;

  // Decode of the request and of pin levels for the next state
  logic                   power_bad;
  logic                   req_take;
  logic                   cur_wr;
  logic                   cur_flag;
  logic                   access_done;
  logic                   in_access;
  logic [`DPH_ADDR_W-1:0] own_bell;
  logic [`DPH_ADDR_W-1:0] peer_bell;
  logic [`DPH_ADDR_W-1:0] req_addr_map;
  logic [`DPH_TMR_W-1:0]  access_load;

  assign power_bad    = !i_supply_ok || i_retention;
  assign o_req_ready  = (state_reg == S_IDLE) && !power_bad;
  assign req_take     = o_req_ready && i_req_valid;
  assign cur_wr       = is_write(cmd_reg);
  assign cur_flag     = is_flag(cmd_reg);
  assign in_access    = (state_next == S_ACCESS);
  assign access_done  = tif.done && i_busy_n;
  assign own_bell     = SIDE_LEFT ? `DPH_BELL_BELOW : `DPH_BELL_TOP;
  assign peer_bell    = SIDE_LEFT ? `DPH_BELL_TOP : `DPH_BELL_BELOW;
  assign req_addr_map = (i_req_cmd == CMD_RING) ? peer_bell :
                        (i_req_cmd == CMD_ACK)  ? own_bell :
                        i_req_addr;
  // Flag pulses never shorter than the flag update width
  assign access_load  = cur_wr ?
                        ld((WR_CYC > FLAG_CYC) ? WR_CYC : FLAG_CYC) :
                        ld((RD_CYC > FLAG_CYC) ? RD_CYC : FLAG_CYC);

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    tif.load   = 1'b0;
    tif.value  = '0;
    case (state_reg)
      S_PWRUP:
      begin
        if (power_bad)
        begin
          tif.load  = 1'b1;
          tif.value = ld(`DPH_PWRUP_CYC);
        end
        else if (tif.done && !i_retention)
          state_next = S_IDLE;
      end
      S_IDLE:
      begin
        if (req_take)
          state_next = S_SETUP;
      end
      S_SETUP:
      begin
        state_next = S_ACCESS;
        tif.load   = 1'b1;
        tif.value  = access_load;
      end
      S_ACCESS:
      begin
        if (!i_busy_n)
        begin
          tif.load  = 1'b1;
          tif.value = cur_wr ? ld(`DPH_HOLD_REL_CYC)
                             : ld(`DPH_REL_DATA_CYC);
        end
        else if (tif.done)
        begin
          state_next = S_END;
          tif.load   = 1'b1;
          tif.value  = ld(GAP_CYC);
        end
      end
      S_END:
      begin
        if (tif.done)
          state_next = S_IDLE;
      end
      default:
        state_next = S_PWRUP;
    endcase
    if (power_bad && state_reg != S_PWRUP)
    begin
      state_next = S_PWRUP;
      tif.load   = 1'b1;
      tif.value  = ld(`DPH_PWRUP_CYC);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= S_PWRUP;
      cmd_reg   <= CMD_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (req_take)
      begin
        cmd_reg   <= i_req_cmd;
        addr_reg  <= req_addr_map;
        wdata_reg <= i_req_wdata;
      end
    end
  end

  // Pin registers follow the next state
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sel_reg    <= 1'b1;
      flag_reg   <= 1'b1;
      strobe_reg <= 1'b1;
      gate_reg   <= 1'b1;
      oe_reg     <= 1'b0;
    end
    else
    begin
      sel_reg    <= !(in_access && !cur_flag);
      flag_reg   <= !(in_access && cur_flag);
      strobe_reg <= !(in_access && cur_wr);
      gate_reg   <= !(in_access && !cur_wr);
      oe_reg     <= in_access && cur_wr;
    end
  end

  // Read capture, response and doorbell
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
      bell_reg  <= 1'b0;
    end
    else
    begin
      if (state_reg == S_ACCESS && access_done && !cur_wr)
        rdata_reg <= i_data;
      rsp_reg  <= (state_reg == S_END) && tif.done && !power_bad;
      bell_reg <= !i_doorbell_n;
    end
  end

  assign o_rsp_valid     = rsp_reg;
  assign o_rsp_rdata     = rdata_reg;
  assign o_doorbell      = bell_reg;
  assign o_sel_n         = sel_reg;
  assign o_flag_select_n = flag_reg;
  assign o_strobe_n      = strobe_reg;
  assign o_gate_n        = gate_reg;
  assign o_addr          = addr_reg;
  assign o_data          = wdata_reg;
  assign o_data_oe       = oe_reg;

  // Checks
  a_sel_exclusive: assert property (@(posedge i_clk) disable iff (i_reset)
    !(!o_sel_n && !o_flag_select_n))
    else $error("memory and flag selected together");
  a_addr_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    !$stable(o_addr) |-> o_sel_n && o_flag_select_n &&
    $past(o_sel_n) && $past(o_flag_select_n))
    else $error("address moved while selected");
  a_addr_hold_end: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_strobe_n) |-> $stable(o_addr) ##1 $stable(o_addr))
    else $error("address not held after write end");
  a_write_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(o_strobe_n) && !i_retention |-> o_gate_n throughout
    (!o_strobe_n [*4]))
    else $error("write pulse short or gate low");
  a_no_contend: assert property (@(posedge i_clk) disable iff (i_reset)
    o_data_oe |-> o_gate_n && $past(o_gate_n, 3))
    else $error("data driven against device outputs");
  a_busy_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_busy_n && !o_strobe_n && !power_bad ##1 i_busy_n && !power_bad
    |=> !o_strobe_n [*3])
    else $error("strobe released early after busy");
  a_flag_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(o_flag_select_n) && !power_bad |->
    !o_flag_select_n [*3])
    else $error("flag update pulse short");
  a_flag_gap: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_flag_select_n) |-> o_flag_select_n [*3])
    else $error("flag readback too soon");
  a_retention: assert property (@(posedge i_clk) disable iff (i_reset)
    i_retention |=> o_sel_n && o_flag_select_n)
    else $error("select active during retention");
  a_addr_first: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(o_sel_n) |-> $stable(o_addr))
    else $error("address not valid at select");
  a_read_strobe: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_gate_n |-> o_strobe_n)
    else $error("strobe low during read");
endmodule

// ### rtl/dpram_host_defines.svh
// Timing counts, pin addresses and widths for the dual-port RAM host
`ifndef DPRAM_HOST_DEFINES_SVH
`define DPRAM_HOST_DEFINES_SVH

`define DPH_PERIOD_PS      4000
`define DPH_ADDR_W         15
`define DPH_DATA_W         9
`define DPH_TMR_W          4
`define DPH_BELL_TOP       15'h7FFF
`define DPH_BELL_BELOW     15'h7FFE
`define DPH_FLAG_BIT       0

`define DPH_CYC(ns) (((ns) * 1000 + `DPH_PERIOD_PS - 1) / `DPH_PERIOD_PS)

`define DPH_WR_PULSE_NS    15
`define DPH_WR_PULSE_CYC   `DPH_CYC(`DPH_WR_PULSE_NS)
`define DPH_RD_ACCESS_NS   20
`define DPH_RD_ACCESS_CYC  `DPH_CYC(`DPH_RD_ACCESS_NS)
`define DPH_FLAG_PULSE_NS  10
`define DPH_FLAG_PULSE_CYC `DPH_CYC(`DPH_FLAG_PULSE_NS)
`define DPH_HOLD_REL_NS    15
`define DPH_HOLD_REL_CYC   `DPH_CYC(`DPH_HOLD_REL_NS)
`define DPH_REL_DATA_NS    20
`define DPH_REL_DATA_CYC   `DPH_CYC(`DPH_REL_DATA_NS)
`define DPH_OUT_OFF_NS     12
`define DPH_OUT_OFF_CYC    `DPH_CYC(`DPH_OUT_OFF_NS)
`define DPH_FLAG_W2R_NS    5
`define DPH_FLAG_W2R_CYC   `DPH_CYC(`DPH_FLAG_W2R_NS)
`define DPH_RD_CYCLE_NS    20
`define DPH_PWRUP_CYC      (`DPH_CYC(`DPH_RD_CYCLE_NS) + 1)

`endif

// ### rtl/dpram_host_pkg.sv
// Types for the dual-port RAM host controller
package dpram_host_pkg;

  typedef enum logic [1:0]
  {
    ST_PWRUP,
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS
  } state_raw_t;

  typedef enum
  {
    S_PWRUP,
    S_IDLE,
    S_SETUP,
    S_ACCESS,
    S_END
  } state_t;

  typedef enum logic [2:0]
  {
    CMD_READ,
    CMD_WRITE,
    CMD_FLAG_WRITE,
    CMD_FLAG_READ,
    CMD_RING,
    CMD_ACK
  } cmd_t;

endpackage

// ### rtl/wait_timer_if.sv
// Load and done signals between the host sequencer and its wait timer
`timescale 1ns/1ps
`include "dpram_host_defines.svh"

interface wait_timer_if;
  logic                  load;
  logic [`DPH_TMR_W-1:0] value;
  logic                  done;

  modport ctrl (output load, output value, input done);
  modport tmr  (input load, input value, output done);
endinterface

// ### rtl/wait_timer.sv
// Down counter that times each phase of a pin cycle
`timescale 1ns/1ps
`include "dpram_host_defines.svh"

module wait_timer
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  // Load and done
  wait_timer_if.tmr  tif
);
  logic [`DPH_TMR_W-1:0] cnt_reg;
  logic [`DPH_TMR_W-1:0] cnt_next;

  assign cnt_next = tif.load ? tif.value
                  : (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign tif.done = (cnt_reg == '0);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      cnt_reg <= `DPH_TMR_W'(`DPH_PWRUP_CYC - 1);
    else
      cnt_reg <= cnt_next;
  end
endmodule

// ### tb/dpram_dev_model.sv
// Behavioural model of one device port facing the host
`timescale 1ns/1ps
`include "dpram_host_defines.svh"

module dpram_dev_model
(
  // Clock
  input  wire logic                   i_clk,
  // Host pins
  input  wire logic                   i_sel_n,
  input  wire logic                   i_flag_select_n,
  input  wire logic                   i_strobe_n,
  input  wire logic                   i_gate_n,
  input  wire logic [`DPH_ADDR_W-1:0] i_addr,
  input  wire logic [`DPH_DATA_W-1:0] i_data,
  output      logic [`DPH_DATA_W-1:0] o_data,
  output      logic                   o_busy_n,
  output      logic                   o_doorbell_n,
  // Far port stand-in
  input  wire logic                   i_busy,
  input  wire logic                   i_ring,
  input  wire logic                   i_peer_holds,
  output      logic                   o_peer_bell,
  output      logic                   o_token
);
  logic [8:0] mem [16];
  logic [8:0] junk;
  logic       want;
  logic       peer_q;
  wire        rd_mem  = !i_sel_n && !i_gate_n && i_strobe_n;
  wire        rd_flag = !i_flag_select_n && !i_gate_n && i_strobe_n;
  wire        wr_mem  = !i_sel_n && !i_strobe_n && o_busy_n;
  wire        wr_flag = !i_flag_select_n && !i_strobe_n;

  initial
  begin
    for (int k = 0; k < 16; k++) mem[k] = 9'h000;
    junk = 9'h155;
    o_token = 1'b0;
    want = 1'b0;
    peer_q = 1'b0;
    o_peer_bell = 1'b0;
    o_doorbell_n = 1'b1;
  end

  // Far-port stand-in decides collisions; busy goes to this port only
  assign o_busy_n = !i_busy;
  // Released bus toggles each cycle
  assign o_data = rd_mem ? mem[i_addr[3:0]] :
                  rd_flag ? {8'h00, !o_token} : junk;

  always @(posedge i_clk) junk <= ~junk;

  always @*
  begin
    if (wr_mem) mem[i_addr[3:0]] = i_data;
  end

  always @(posedge i_clk)
  begin
    peer_q <= i_peer_holds;
    if (wr_flag && !i_data[0] && !i_peer_holds) o_token <= 1'b1;
    if (wr_flag && !i_data[0] && i_peer_holds) want <= 1'b1;
    if (want && peer_q && !i_peer_holds)
    begin
      o_token <= 1'b1;
      want <= 1'b0;
    end
    if (wr_flag && i_data[0]) o_token <= 1'b0;
    if (wr_mem && i_addr == `DPH_BELL_TOP) o_peer_bell <= 1'b1;
    if (i_ring) o_doorbell_n <= 1'b0;
    if (rd_mem && i_addr == `DPH_BELL_BELOW) o_doorbell_n <= 1'b1;
  end
endmodule

// ### tb/async_dual_port_ram_access_tb.sv
// Self-checking bench for the dual-port RAM host controller
`timescale 1ns/1ps
`include "dpram_host_defines.svh"

module async_dual_port_ram_access_tb;
  import dpram_host_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sup = 1'b1, ret = 1'b0;
  logic        valid = 1'b0, busy = 1'b0, ring = 1'b0, held = 1'b0;
  cmd_t        cmd = CMD_READ;
  logic [14:0] addr = 15'h0000, o_addr, pa;
  logic [8:0]  wdata = 9'h000, o_data, i_data, rdata, rd;
  logic        ready, rsp, bell, sel_n, fsel_n, str_n, gate_n, oe;
  logic        busy_n, bell_n, pbell, token, ps = 1'b1;
  int          num_errors = 0, checked = 0, cyc = 0, cnt;

  dpram_host dut_u (.i_clk(clk), .i_reset(rst), .i_supply_ok(sup),
    .i_retention(ret), .i_req_valid(valid), .i_req_cmd(cmd),
    .i_req_addr(addr), .i_req_wdata(wdata), .o_req_ready(ready),
    .o_rsp_valid(rsp), .o_rsp_rdata(rdata), .o_doorbell(bell),
    .o_sel_n(sel_n), .o_flag_select_n(fsel_n), .o_strobe_n(str_n),
    .o_gate_n(gate_n), .o_addr(o_addr), .o_data(o_data),
    .o_data_oe(oe), .i_data(i_data), .i_busy_n(busy_n),
    .i_doorbell_n(bell_n));

  dpram_dev_model model_u (.i_clk(clk), .i_sel_n(sel_n),
    .i_flag_select_n(fsel_n), .i_strobe_n(str_n), .i_gate_n(gate_n),
    .i_addr(o_addr), .i_data(o_data), .o_data(i_data),
    .o_busy_n(busy_n), .o_doorbell_n(bell_n), .i_busy(busy),
    .i_ring(ring), .i_peer_holds(held), .o_peer_bell(pbell),
    .o_token(token));

  always #2 clk = ~clk;

  task automatic check(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Pin monitor
  always @(posedge clk)
  begin
    if (!rst)
    begin
      check("sel_pair", sel_n | fsel_n, 1);
      check("addr_move", o_addr === pa || (ps && sel_n && fsel_n), 1);
      check("retain_sel", !ret || (sel_n && fsel_n), 1);
      check("oe_clash", oe && !gate_n, 0);
      check("rd_strobe", !gate_n && !str_n, 0);
    end
    pa <= o_addr;
    ps <= sel_n && fsel_n;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic ready_wait();
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end while (ready !== 1'b1 && cnt < 300);
    if (ready !== 1'b1) num_errors++;
  endtask

  task automatic req(input cmd_t c, input logic [14:0] a,
                     input logic [8:0] d);
    int n;
    ready_wait();
    @(posedge clk);
    valid <= 1'b1;
    cmd <= c;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (rsp !== 1'b1 && n < 300);
    if (rsp !== 1'b1) num_errors++;
    rd = rdata;
  endtask

  task automatic t_mem();
    req(CMD_WRITE, 15'h0001, 9'h1FF);
    req(CMD_WRITE, 15'h0002, 9'h0A5);
    req(CMD_READ, 15'h0001, 9'h000);
    check("rd1", rd, 9'h1FF);
    req(CMD_READ, 15'h0002, 9'h000);
    check("rd2", rd, 9'h0A5);
    $display("mem test done");
  endtask

  task automatic t_busy();
    @(posedge clk);
    busy <= 1'b1;
    fork
      req(CMD_WRITE, 15'h0003, 9'h0C3);
      begin
        repeat (20) @(posedge clk);
        check("bwr_hold", model_u.mem[3], 9'h000);
        busy <= 1'b0;
      end
    join
    @(posedge clk);
    busy <= 1'b1;
    fork
      req(CMD_READ, 15'h0003, 9'h000);
      begin
        repeat (20) @(posedge clk);
        busy <= 1'b0;
      end
    join
    check("bsy_rd", rd, 9'h0C3);
    $display("busy test done");
  endtask

  task automatic t_bell();
    req(CMD_RING, 15'h0000, 9'h000);
    check("peer_bell", pbell, 1);
    @(posedge clk);
    ring <= 1'b1;
    @(posedge clk);
    ring <= 1'b0;
    repeat (3) @(negedge clk);
    check("bell_set", bell, 1);
    req(CMD_ACK, 15'h0000, 9'h000);
    repeat (3) @(negedge clk);
    check("bell_clr", bell, 0);
    $display("doorbell test done");
  endtask

  task automatic t_flag();
    req(CMD_FLAG_WRITE, 15'h0000, 9'h000);
    req(CMD_FLAG_READ, 15'h0000, 9'h000);
    check("flag_won", rd[0], 0);
    req(CMD_FLAG_WRITE, 15'h0000, 9'h001);
    req(CMD_FLAG_READ, 15'h0000, 9'h000);
    check("flag_free", rd[0], 1);
    @(posedge clk);
    held <= 1'b1;
    req(CMD_FLAG_WRITE, 15'h0000, 9'h000);
    req(CMD_FLAG_READ, 15'h0000, 9'h000);
    check("flag_held", rd[0], 1);
    @(posedge clk);
    held <= 1'b0;
    req(CMD_FLAG_READ, 15'h0000, 9'h000);
    check("flag_pass", rd[0], 0);
    req(CMD_FLAG_WRITE, 15'h0000, 9'h001);
    $display("flag test done");
  endtask

  task automatic t_retain();
    @(posedge clk);
    ret <= 1'b1;
    repeat (4) @(negedge clk);
    check("ret_ready", ready, 0);
    @(posedge clk);
    ret <= 1'b0;
    ready_wait();
    check("ret_wait", cnt > 5, 1);
    req(CMD_READ, 15'h0002, 9'h000);
    check("ret_rd", rd, 9'h0A5);
    $display("retention test done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ready_wait();
    check("pwr_wait", cnt > 5, 1);
    t_mem();
    t_busy();
    t_bell();
    t_flag();
    t_retain();
    test_done();
  end
endmodule
